// [src/scic_top.sv]
// system clock input configuration and stability qualification
`timescale 1ns/1ns
`include "scic_consts.svh"
module scic_top
    import scic_pkg::*;
#(
    parameter int CYC_PER_MS = `SCIC_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave, byte address
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog side
    input wire logic pll_locked,
    output logic xtal_amp_enable,
    output logic [1:0] input_predivider,
    output logic doubler_stage,
    output logic [27:0] ref_freq_hz,
    output logic [7:0] fb_divider,
    output logic system_clock_input_stable,
    output logic update_pulse
);
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [7:0] merge_byte(input logic [7:0] old, input logic [7:0] wd, input logic be);
        merge_byte = be ? wd : old;
    endfunction : merge_byte

    function automatic logic [11:0] word_index(input logic [13:0] addr);
        word_index = addr[13:2];
    endfunction : word_index

    function automatic logic in_span(input logic [11:0] i, input logic [11:0] lo, input logic [11:0] hi);
        in_span = i >= lo && i <= hi;
    endfunction : in_span

    // ----------------------------------------------------------------
    // bus handshake
    // ----------------------------------------------------------------
    // one wait state: the request is taken on the edge where waitrequest is low;
    // waitrequest is a flop of its own so the master never sees a decode glitch
    logic req;
    logic ack;
    logic wr_take;
    logic [11:0] idx;
    logic [7:0] wb;

    assign req = avs_read || avs_write;
    assign ack = !avs_waitrequest;
    assign wr_take = avs_write && ack && avs_byteenable[0];
    assign idx = word_index(avs_address);
    assign wb = avs_writedata[7:0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            // a request still held after its accepting edge counts as a new one
            avs_waitrequest <= !(req && avs_waitrequest);
        end
    end

    // ----------------------------------------------------------------
    // write decode
    // ----------------------------------------------------------------
    logic wr_cfg;
    logic wr_fb;
    logic wr_ref;

    assign wr_cfg = wr_take && idx == `SCIC_IDX_CONFIG;
    assign wr_fb = wr_take && idx == `SCIC_IDX_FB_DIV;
    assign wr_ref = wr_take && in_span(idx, `SCIC_IDX_REF_B0, `SCIC_IDX_REF_B3);

    // ----------------------------------------------------------------
    // configuration register
    // ----------------------------------------------------------------
    localparam logic [3:0] CFG_RESET = `SCIC_CFG_RESET;
    logic [3:0] cfg;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg <= wb[3:0];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            xtal_amp_enable <= CFG_RESET[`SCIC_CFG_XTAL];
        end else begin
            xtal_amp_enable <= cfg[`SCIC_CFG_XTAL];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            input_predivider <= SCIC_PREDIV_1;
        end else begin
            // predivider code selects /1 /2 /4 /8
            input_predivider <= cfg[`SCIC_CFG_PREDIV_HI:`SCIC_CFG_PREDIV_LO];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            doubler_stage <= CFG_RESET[`SCIC_CFG_DOUBLER];
        end else begin
            // doubler switch, no duty-cycle check here
            doubler_stage <= cfg[`SCIC_CFG_DOUBLER];
        end
    end

    // ----------------------------------------------------------------
    // feedback divider and reference frequency
    // ----------------------------------------------------------------
    logic [7:0] fb_div;
    logic [27:0] ref_freq;

    // reset zero, range left to software
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fb_div <= `SCIC_FB_DIV_RESET;
        end else if (wr_fb) begin
            fb_div <= wb;
        end
    end

    // low byte first, top nibble only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_freq <= `SCIC_REF_RESET;
        end else if (wr_ref) begin
            case (idx)
                `SCIC_IDX_REF_B0: ref_freq[7:0] <= wb;
                `SCIC_IDX_REF_B1: ref_freq[15:8] <= wb;
                `SCIC_IDX_REF_B2: ref_freq[23:16] <= wb;
                `SCIC_IDX_REF_B3: ref_freq[27:24] <= wb[3:0];
                default: ref_freq <= ref_freq;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ref_freq_hz <= `SCIC_REF_RESET;
        end else begin
            ref_freq_hz <= ref_freq;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            fb_divider <= `SCIC_FB_DIV_RESET;
        end else begin
            fb_divider <= fb_div;
        end
    end

    // ----------------------------------------------------------------
    // stability period and update strobe
    // ----------------------------------------------------------------
    logic [19:0] stab_period;
    logic stab_written;
    logic upd_take;

    assign stab_written = wr_take && in_span(idx, `SCIC_IDX_STAB_B0, `SCIC_IDX_STAB_B2);
    // update strobe is 0x01 to the update register
    assign upd_take = wr_take && idx == `SCIC_IDX_UPDATE && wb == `SCIC_UPDATE_CODE;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stab_period <= `SCIC_STAB_RESET;
        end else if (stab_written) begin
            case (idx)
                `SCIC_IDX_STAB_B0: stab_period[7:0] <= merge_byte(stab_period[7:0], wb, 1'b1);
                `SCIC_IDX_STAB_B1: stab_period[15:8] <= merge_byte(stab_period[15:8], wb, 1'b1);
                `SCIC_IDX_STAB_B2: stab_period[19:16] <= wb[3:0];
                default: stab_period <= stab_period;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            update_pulse <= 1'b0;
        end else begin
            update_pulse <= upd_take;
        end
    end

    // ----------------------------------------------------------------
    // lock synchroniser
    // ----------------------------------------------------------------
    // pll lock comes from the analog side; accept a change once stages 2 and 3 agree
    logic [2:0] lock_sync;
    logic lock_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_sync <= 3'h0;
        end else begin
            lock_sync <= {lock_sync[1:0], pll_locked};
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lock_q <= 1'b0;
        end else if (lock_sync[1] == lock_sync[2]) begin
            lock_q <= lock_sync[2];
        end
    end

    // ----------------------------------------------------------------
    // stability timer
    // ----------------------------------------------------------------
    scic_tmr_state_t state;
    scic_tmr_state_t next_state;
    logic [19:0] ms_count;
    logic ms_tick;
    logic restart_tick;

    assign restart_tick = state != SCIC_TMR_COUNT;

    scic_ms_tick #(
        .CYC_PER_MS(CYC_PER_MS)
    ) u_ms_tick (
        .core_clk(core_clk),
        .rst(rst),
        .restart(restart_tick),
        .tick(ms_tick)
    );

    always_comb begin
        next_state = state;
        case (state)
            SCIC_TMR_HALT: begin
                // resume only on the update strobe
                if (upd_take) begin
                    next_state = SCIC_TMR_WAIT_LOCK;
                end
            end
            SCIC_TMR_WAIT_LOCK: begin
                if (lock_q) begin
                    next_state = SCIC_TMR_COUNT;
                end
            end
            SCIC_TMR_COUNT: begin
                if (!lock_q) begin
                    next_state = SCIC_TMR_WAIT_LOCK;
                end else if (ms_tick && ms_count + 20'h1 >= stab_period) begin
                    next_state = SCIC_TMR_STABLE;
                end
            end
            SCIC_TMR_STABLE: begin
                if (!lock_q) begin
                    next_state = SCIC_TMR_WAIT_LOCK;
                end
            end
            default: next_state = SCIC_TMR_WAIT_LOCK;
        endcase
        // applied last so a period write outranks any lock event
        // a period write stops and clears the timer
        if (stab_written) begin
            next_state = SCIC_TMR_HALT;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state <= SCIC_TMR_WAIT_LOCK;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ms_count <= 20'h0;
        end else if (next_state != SCIC_TMR_COUNT || state != SCIC_TMR_COUNT) begin
            ms_count <= 20'h0;
        end else if (ms_tick) begin
            ms_count <= ms_count + 20'h1;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            system_clock_input_stable <= 1'b0;
        end else begin
            system_clock_input_stable <= next_state == SCIC_TMR_STABLE;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    logic [7:0] rd_byte;

    always_comb begin
        case (idx)
            `SCIC_IDX_FB_DIV: rd_byte = fb_div;
            `SCIC_IDX_CONFIG: rd_byte = {4'h0, cfg};
            `SCIC_IDX_REF_B0: rd_byte = ref_freq[7:0];
            `SCIC_IDX_REF_B1: rd_byte = ref_freq[15:8];
            `SCIC_IDX_REF_B2: rd_byte = ref_freq[23:16];
            `SCIC_IDX_REF_B3: rd_byte = {4'h0, ref_freq[27:24]};
            `SCIC_IDX_STAB_B0: rd_byte = stab_period[7:0];
            `SCIC_IDX_STAB_B1: rd_byte = stab_period[15:8];
            `SCIC_IDX_STAB_B2: rd_byte = {4'h0, stab_period[19:16]};
            `SCIC_IDX_STATUS: rd_byte = {5'h00, lock_q, state == SCIC_TMR_COUNT, state == SCIC_TMR_STABLE};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0;
        end else if (avs_read && !ack) begin
            avs_readdata <= {24'h0, rd_byte};
        end
    end
endmodule : scic_top

// [src/scic_consts.svh]
// constants for the system clock input configuration block
`ifndef SCIC_CONSTS_SVH
`define SCIC_CONSTS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define SCIC_IDX_UPDATE 12'h00f
`define SCIC_IDX_FB_DIV 12'h200
`define SCIC_IDX_CONFIG 12'h201
`define SCIC_IDX_REF_B0 12'h202
`define SCIC_IDX_REF_B1 12'h203
`define SCIC_IDX_REF_B2 12'h204
`define SCIC_IDX_REF_B3 12'h205
`define SCIC_IDX_STAB_B0 12'h206
`define SCIC_IDX_STAB_B1 12'h207
`define SCIC_IDX_STAB_B2 12'h208
`define SCIC_IDX_STATUS 12'h209

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SCIC_UPDATE_CODE 8'h01
`define SCIC_CFG_DOUBLER 0
`define SCIC_CFG_PREDIV_LO 1
`define SCIC_CFG_PREDIV_HI 2
`define SCIC_CFG_XTAL 3
`define SCIC_CFG_RESET 4'h8
`define SCIC_FB_DIV_RESET 8'h00
`define SCIC_REF_RESET 28'h0000000
`define SCIC_STAB_RESET 20'h00032
`define SCIC_NIBBLE_MASK 8'h0f

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SCIC_CLK_HZ 100000000
`define SCIC_MS_PER_S 1000
`define SCIC_CYC_PER_MS (`SCIC_CLK_HZ / `SCIC_MS_PER_S)

`endif

// [src/scic_pkg.sv]
// types for the system clock input configuration block
package scic_pkg;
    typedef enum logic [1:0] {
        SCIC_TMR_HALT,
        SCIC_TMR_WAIT_LOCK,
        SCIC_TMR_COUNT,
        SCIC_TMR_STABLE
    } scic_tmr_state_t;

    typedef enum logic [1:0] {
        SCIC_PREDIV_1,
        SCIC_PREDIV_2,
        SCIC_PREDIV_4,
        SCIC_PREDIV_8
    } scic_prediv_t;
endpackage : scic_pkg

// [src/scic_ms_tick.sv]
// millisecond tick generator, restartable
`timescale 1ns/1ns
`include "scic_consts.svh"
module scic_ms_tick #(
    parameter int CYC_PER_MS = `SCIC_CYC_PER_MS
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic restart,
    output logic tick
);
    localparam int CW = $clog2(CYC_PER_MS + 1);
    localparam logic [CW-1:0] LAST = CW'(CYC_PER_MS - 1);

    logic [CW-1:0] cnt;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cnt <= '0;
        end else if (restart || cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + CW'(1);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= !restart && cnt == LAST;
        end
    end
endmodule : scic_ms_tick

// [verification/scic_osc_model.sv]
// crystal or oscillator with the system clock pll lock behaviour
`timescale 1ns/1ns
module scic_osc_model #(
    parameter int LOCK_DLY = 7
) (
    input wire logic core_clk,
    input wire logic osc_on,
    input wire logic duty_ok,
    input wire logic doubler_stage,
    output logic pll_locked
);
    int cnt = 0;
    always @(posedge core_clk) begin
        if (!osc_on || (doubler_stage && !duty_ok)) cnt <= 0;
        else if (cnt < LOCK_DLY) cnt <= cnt + 1;
    end
    assign pll_locked = (cnt == LOCK_DLY);
endmodule : scic_osc_model

// [verification/scic_top_props.sv]
// concurrent checks on the ports of the system clock input block
`timescale 1ns/1ns
module scic_top_props #(
    parameter int CYC_PER_MS = 10
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [13:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic pll_locked,
    input wire logic xtal_amp_enable,
    input wire logic [1:0] input_predivider,
    input wire logic doubler_stage,
    input wire logic [27:0] ref_freq_hz,
    input wire logic [7:0] fb_divider,
    input wire logic system_clock_input_stable,
    input wire logic update_pulse
);
    logic [19:0] lock_run;
    logic wr_ok;
    logic [11:0] idx;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign idx = avs_address[13:2];
    // raw lock length, saturating
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) lock_run <= '0;
        else if (!pll_locked) lock_run <= '0;
        else if (lock_run != 20'hfffff) lock_run <= lock_run + 20'h1;
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_cfg_wr; wr_ok && idx == 12'h201; endsequence
    sequence s_stab_wr; wr_ok && idx >= 12'h206 && idx <= 12'h208; endsequence
    sequence s_upd_wr; wr_ok && idx == 12'h00f && avs_writedata[7:0] == 8'h01; endsequence
    property p_wait_ans; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    property p_prediv; s_cfg_wr |=> ##1 input_predivider == $past(avs_writedata[2:1], 2); endproperty
    property p_xtal; s_cfg_wr |=> ##1 xtal_amp_enable == $past(avs_writedata[3], 2); endproperty
    property p_dbl; s_cfg_wr |=> ##1 doubler_stage == $past(avs_writedata[0], 2); endproperty
    property p_ref_top; wr_ok && idx == 12'h205 |=> ##1 ref_freq_hz[27:24] == $past(avs_writedata[3:0], 2); endproperty
    property p_stab_wr; s_stab_wr |=> ##1 !system_clock_input_stable [*7]; endproperty
    property p_upd; s_upd_wr |=> ##[0:1] update_pulse; endproperty
    property p_unlock; !pll_locked [*6] |=> !system_clock_input_stable; endproperty
    property p_stable; $rose(system_clock_input_stable) |-> lock_run >= CYC_PER_MS; endproperty
    a_wait_ans: assert property (p_wait_ans) else $error("no answer one cycle after request");
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low for more than one cycle");
    a_prediv: assert property (p_prediv) else $error("predivider not taken from write");
    a_xtal: assert property (p_xtal) else $error("crystal enable not taken from write");
    a_dbl: assert property (p_dbl) else $error("doubler not taken from write");
    a_ref_top: assert property (p_ref_top) else $error("reference top nibble wrong");
    a_stab_wr: assert property (p_stab_wr) else $error("stable after period write");
    a_upd: assert property (p_upd) else $error("no update pulse");
    a_unlock: assert property (p_unlock) else $error("stable without lock");
    a_stable: assert property (p_stable) else $error("stable too early after lock");
endmodule : scic_top_props
bind scic_top scic_top_props #(.CYC_PER_MS(CYC_PER_MS)) u_props (.core_clk(core_clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pll_locked(pll_locked), .xtal_amp_enable(xtal_amp_enable), .input_predivider(input_predivider),
    .doubler_stage(doubler_stage), .ref_freq_hz(ref_freq_hz), .fb_divider(fb_divider),
    .system_clock_input_stable(system_clock_input_stable), .update_pulse(update_pulse));

// [verification/testbench.sv]
// self-checking bench for the system clock input configuration block
`timescale 1ns/1ns
module testbench;
    localparam int CPM = 10;
    localparam logic [11:0] RST_IDX [11] = '{12'h201, 12'h202, 12'h203, 12'h204, 12'h205, 12'h206,
        12'h207, 12'h208, 12'h200, 12'h00f, 12'h300};
    localparam logic [7:0] RST_VAL [11] = '{8'h08, 8'h00, 8'h00, 8'h00, 8'h00, 8'h32, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00};
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [13:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = '0;
    logic [3:0] avs_byteenable = 4'hf;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, pll_locked, xtal_amp_enable, doubler_stage, system_clock_input_stable, update_pulse;
    logic [1:0] input_predivider;
    logic [27:0] ref_freq_hz;
    logic [7:0] fb_divider;
    logic osc_on = 1'b0;
    logic duty_ok = 1'b1;
    int n_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int n_upd = 0;
    logic [31:0] lfsr = 32'hb2bf;
    logic [31:0] exp_q [$];
    logic [7:0] r [4];

    always #5 core_clk = ~core_clk;

    scic_top #(.CYC_PER_MS(CPM)) u_dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pll_locked(pll_locked), .xtal_amp_enable(xtal_amp_enable), .input_predivider(input_predivider),
        .doubler_stage(doubler_stage), .ref_freq_hz(ref_freq_hz), .fb_divider(fb_divider),
        .system_clock_input_stable(system_clock_input_stable), .update_pulse(update_pulse));
    scic_osc_model u_osc (.core_clk(core_clk), .osc_on(osc_on), .duty_ok(duty_ok),
        .doubler_stage(doubler_stage), .pll_locked(pll_locked));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : rnd

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic results();
        if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // request held until the rising edge that samples waitrequest low; outputs settle one edge later
    task automatic bus(input logic rd, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] be);
        if (rd) exp_q.push_back({24'h0, d});
        @(posedge core_clk);
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h0, d};
        avs_byteenable <= be;
        avs_read <= rd;
        avs_write <= !rd;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : bus

    // lower bound lets one ms tick of phase slack, upper bound the sync and lock delay
    task automatic qualify(input int ms);
        repeat (ms * CPM - CPM - 5) @(negedge core_clk);
        check(system_clock_input_stable, 1'b0);
        repeat (40) if (system_clock_input_stable !== 1'b1) @(negedge core_clk);
        check(system_clock_input_stable, 1'b1);
    endtask : qualify

    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) check(avs_readdata, exp_q.pop_front());
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (update_pulse === 1'b1) n_upd <= n_upd + 1;
        if (cycles == 6000) begin
            n_errors++;
            results();
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        @(negedge core_clk);
        check({xtal_amp_enable, input_predivider, doubler_stage}, 4'h8);
        foreach (RST_IDX[k]) bus(1'b1, RST_IDX[k], RST_VAL[k], 4'hf);
        for (int i = 0; i < 16; i++) begin
            bus(1'b0, 12'h201, 8'ha0 | i[7:0], 4'hf);
            check({xtal_amp_enable, input_predivider, doubler_stage}, i);
            bus(1'b1, 12'h201, i[7:0], 4'hf);
        end
        bus(1'b0, 12'h201, 8'h00, 4'h0);
        bus(1'b1, 12'h201, 8'h0f, 4'hf);
        for (int k = 0; k < 4; k++) begin
            lfsr = rnd(lfsr);
            r[k] = lfsr[7:0];
            bus(1'b0, 12'h202 + k[11:0], r[k], 4'hf);
        end
        check(ref_freq_hz, {r[3][3:0], r[2], r[1], r[0]});
        bus(1'b1, 12'h205, r[3] & 8'h0f, 4'hf);
        lfsr = rnd(lfsr);
        bus(1'b0, 12'h200, lfsr[7:0], 4'hf);
        check(fb_divider, lfsr[7:0]);
        bus(1'b0, 12'h201, 8'h08, 4'hf);
        osc_on <= 1'b1;
        qualify(50);
        bus(1'b1, 12'h209, 8'h05, 4'hf);
        for (int k = 0; k < 3; k++) bus(1'b0, 12'h206 + k[11:0], (k == 0) ? 8'h03 : 8'h00, 4'hf);
        bus(1'b0, 12'h00f, 8'h02, 4'hf);
        repeat (100) @(negedge core_clk);
        check(system_clock_input_stable, 1'b0);
        bus(1'b1, 12'h209, 8'h04, 4'hf);
        bus(1'b0, 12'h00f, 8'h01, 4'hf);
        check(n_upd, 1);
        qualify(3);
        duty_ok <= 1'b0;
        bus(1'b0, 12'h201, 8'h09, 4'hf);
        repeat (15) @(negedge core_clk);
        check(system_clock_input_stable, 1'b0);
        duty_ok <= 1'b1;
        qualify(3);
        osc_on <= 1'b0;
        repeat (10) @(negedge core_clk);
        check(system_clock_input_stable, 1'b0);
        osc_on <= 1'b1;
        qualify(3);
        results();
    end
endmodule : testbench
